// File: rtl/dtmc_regs.vh
// Register indices, field positions, reset values and timing counts of the dual timer.
`ifndef DTMC_REGS_VH
`define DTMC_REGS_VH

// ********************
// Register indices (byte address is four times the index)
// ********************
`define DTMC_IDX_CTRL      8'h88
`define DTMC_IDX_MODE      8'h89
`define DTMC_IDX_T0_LOW    8'h8a
`define DTMC_IDX_T1_LOW    8'h8b
`define DTMC_IDX_T0_HIGH   8'h8c
`define DTMC_IDX_T1_HIGH   8'h8d
`define DTMC_IDX_CLKSEL    8'h8e

// ********************
// Field positions
// ********************
`define DTMC_MODE_TIMER_ONE_GATE_ENABLE    7
`define DTMC_MODE_CT1      6
`define DTMC_MODE_M1_HI    5
`define DTMC_MODE_M1_LO    4
`define DTMC_MODE_TIMER_ZERO_GATE_ENABLE    3
`define DTMC_MODE_CT0      2
`define DTMC_MODE_M0_HI    1
`define DTMC_MODE_M0_LO    0
`define DTMC_CTRL_TF1      7
`define DTMC_CTRL_TR1      6
`define DTMC_CTRL_TF0      5
`define DTMC_CTRL_TR0      4
`define DTMC_CKS_PRE_HI    1
`define DTMC_CKS_PRE_LO    0
`define DTMC_CKS_BYP0      2
`define DTMC_CKS_BYP1      3
`define DTMC_CKS_POL0      4
`define DTMC_CKS_POL1      5

// ********************
// Encodings, reset values and divider counts
// ********************
`define DTMC_M_13BIT       2'h0
`define DTMC_M_16BIT       2'h1
`define DTMC_M_RELOAD      2'h2
`define DTMC_M_SPLIT       2'h3
`define DTMC_PRE_DIV12     2'h0
`define DTMC_PRE_DIV4      2'h1
`define DTMC_PRE_DIV48     2'h2
`define DTMC_PRE_EXT8      2'h3
`define DTMC_RST_BYTE      8'h00
`define DTMC_DIV12_LAST    4'hb
`define DTMC_DIV4_LAST     2'h3
`define DTMC_EXT8_LAST     3'h7

`endif

// File: rtl/dtmc_timer.v
// Two counter/timers with their shared mode register behind an Avalon-MM slave.
`timescale 1ns/1ps
`include "dtmc_regs.vh"

// What this block does
// - Split mode runs timer zero as two independent 8-bit counters.
// - Split low byte uses timer zero run, count select, gate and overflow flag.
// - Split low byte counts system or prescaled clock, or external pin by select.
// - Split high byte is timer only, never clocked by the external pin.
// - Split high byte counts only while timer one run bit is set.
// - Split high byte overflow sets timer one overflow flag.
// - During split, timer one ignores its pin and never sets its flag.
// - During split, timer one overflows still reach other peripherals as ticks.
// - During split, timer one runs in modes 0-2, stops in mode 3.
// - Timer one gate: with gate set, count needs run and active pin.
// - Timer one select: clock tick, or falling edges of its count pin.
// - Timer one mode: 13-bit, 16-bit, 8-bit reload, inactive.
// - Timer zero gate: with gate set, count needs run and active pin.
// - Prescale picks /12, /4, /48 or external/8; bypass bit uses system clock.
// - Timer zero select: clock tick, or falling edges of its count pin.
// - Timer zero mode: 13-bit, 16-bit, 8-bit reload, split.
module dtmc_timer
(
   input  wire        clock,
   input  wire        sys_rst,
   input  wire [9:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   input  wire [3:0]  byteenable,
   output reg  [31:0] readdata,
   output reg         waitrequest,
   input  wire        timer_zero_count_pin,
   input  wire        timer_one_count_pin,
   input  wire        ext_irq_zero_pin,
   input  wire        ext_irq_one_pin,
   input  wire        external_clock,
   output reg         timer_zero_overflow_flag,
   output reg         timer_one_overflow_flag,
   output reg         timer_one_overflow_tick
);

   // ********************
   // One counting step for a byte pair
   // ********************

   // Returns {overflow, high, low}. Mode split steps the low byte alone.
   function [16:0] dtmc_step;
      input [1:0] mode;
      input [7:0] lo;
      input [7:0] hi;
      input       inc;
      begin
         dtmc_step = {1'b0, hi, lo};
         if (inc)
         begin
            case (mode)
               `DTMC_M_13BIT:
               begin
                  if (lo[4:0] == 5'h1f)
                     dtmc_step = {(hi == 8'hff), hi + 8'h01, lo[7:5], 5'h00};
                  else
                     dtmc_step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
               end
               `DTMC_M_16BIT:
                  dtmc_step = {({hi, lo} == 16'hffff), {hi, lo} + 16'h0001};
               `DTMC_M_RELOAD:
               begin
                  if (lo == 8'hff)
                     dtmc_step = {1'b1, hi, hi};
                  else
                     dtmc_step = {1'b0, hi, lo + 8'h01};
               end
               default:
                  dtmc_step = {(lo == 8'hff), hi, lo + 8'h01};
            endcase
         end
      end
   endfunction

   // ********************
   // Registers and internal signals
   // ********************
   reg  [7:0]  mode_reg;
   reg  [7:0]  ctrl_reg;
   reg  [7:0]  clksel_reg;
   reg  [7:0]  t0_low_reg;
   reg  [7:0]  t0_high_reg;
   reg  [7:0]  t1_low_reg;
   reg  [7:0]  t1_high_reg;
   reg  [4:0]  sync1_reg;
   reg  [4:0]  sync2_reg;
   reg  [4:0]  sync3_reg;
   reg  [3:0]  div12_reg;
   reg  [1:0]  div48_reg;
   reg  [1:0]  div4_reg;
   reg  [2:0]  ext8_reg;
   reg  [31:0] rdata_next;
   wire [7:0]  idx;
   wire        hit;
   wire        wr_go;
   wire        tick12;
   wire        tick48;
   wire        tick4;
   wire        tick_ext8;
   reg         pre_tick;
   wire        split;
   wire        fall0;
   wire        fall1;
   wire        act0;
   wire        act1;
   wire        clk0;
   wire        clk1;
   wire        run0;
   wire        run1;
   wire        inc0;
   wire        inc0_high;
   wire        inc1;
   wire [16:0] step0;
   wire [16:0] step0_high;
   wire [16:0] step1;

   // Avalon word index; only aligned accesses with lane zero enabled write.
   assign idx   = address[9:2];
   assign hit   = (address[9:8] == 2'h2) && (address[1:0] == 2'h0);
   assign wr_go = write && !waitrequest && hit && byteenable[0];

   // ********************
   // Pin synchronisers
   // ********************

   // Bit order: 0 count0, 1 count1, 2 irq0, 3 irq1, 4 external clock.
   // The third stage only holds the previous synchronised value for edges.
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         sync1_reg <= 5'h1f;
         sync2_reg <= 5'h1f;
         sync3_reg <= 5'h1f;
      end
      else
      begin
         sync1_reg <= {external_clock, ext_irq_one_pin, ext_irq_zero_pin,
                       timer_one_count_pin, timer_zero_count_pin};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign fall0 = sync3_reg[0] && !sync2_reg[0];
   assign fall1 = sync3_reg[1] && !sync2_reg[1];

   // Interrupt pin is active when its level equals the polarity bit.
   assign act0 = (sync2_reg[2] == clksel_reg[`DTMC_CKS_POL0]);
   assign act1 = (sync2_reg[3] == clksel_reg[`DTMC_CKS_POL1]);

   // ********************
   // Prescaler
   // ********************

   // The divide-by-48 rides on the divide-by-12 so both share one counter.
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         div12_reg <= 4'h0;
         div48_reg <= 2'h0;
         div4_reg  <= 2'h0;
         ext8_reg  <= 3'h0;
      end
      else
      begin
         div4_reg  <= div4_reg + 2'h1;
         div12_reg <= tick12 ? 4'h0 : div12_reg + 4'h1;
         if (tick12)
            div48_reg <= div48_reg + 2'h1;
         if (sync2_reg[4] && !sync3_reg[4])
            ext8_reg <= ext8_reg + 3'h1;
      end
   end

   assign tick12    = (div12_reg == `DTMC_DIV12_LAST);
   assign tick48    = tick12 && (div48_reg == `DTMC_DIV4_LAST);
   assign tick4     = (div4_reg == `DTMC_DIV4_LAST);
   // External clock must run well below half the system clock to be seen.
   assign tick_ext8 = sync2_reg[4] && !sync3_reg[4] && (ext8_reg == `DTMC_EXT8_LAST);

   // Prescale select decode.
   always @*
   begin
      case (clksel_reg[`DTMC_CKS_PRE_HI:`DTMC_CKS_PRE_LO])
         `DTMC_PRE_DIV12: pre_tick = tick12;
         `DTMC_PRE_DIV4:  pre_tick = tick4;
         `DTMC_PRE_DIV48: pre_tick = tick48;
         default:         pre_tick = tick_ext8;
      endcase
   end

   // Bypass bit uses every system clock cycle.
   assign clk0 = clksel_reg[`DTMC_CKS_BYP0] | pre_tick;
   assign clk1 = clksel_reg[`DTMC_CKS_BYP1] | pre_tick;

   // ********************
   // Count enables
   // ********************
   assign split = (mode_reg[`DTMC_MODE_M0_HI:`DTMC_MODE_M0_LO] == `DTMC_M_SPLIT);

   assign run0 = ctrl_reg[`DTMC_CTRL_TR0] &&
                 (!mode_reg[`DTMC_MODE_TIMER_ZERO_GATE_ENABLE] || act0);
   assign inc0 = run0 && (mode_reg[`DTMC_MODE_CT0] ? fall0 : clk0);

   // High byte of a split timer zero: timer only, run by timer one run bit.
   assign inc0_high = split && ctrl_reg[`DTMC_CTRL_TR1] && clk0;

   // In split, timer one runs from its mode field alone, on its clock only.
   assign run1 = split ? 1'b1 :
                 (ctrl_reg[`DTMC_CTRL_TR1] &&
                  (!mode_reg[`DTMC_MODE_TIMER_ONE_GATE_ENABLE] || act1));
   assign inc1 = run1 &&
                 (mode_reg[`DTMC_MODE_M1_HI:`DTMC_MODE_M1_LO] != `DTMC_M_SPLIT) &&
                 ((mode_reg[`DTMC_MODE_CT1] && !split) ? fall1 : clk1);

   assign step0      = dtmc_step(mode_reg[`DTMC_MODE_M0_HI:`DTMC_MODE_M0_LO],
                                 t0_low_reg, t0_high_reg, inc0);
   assign step0_high = dtmc_step(`DTMC_M_SPLIT, t0_high_reg, 8'h00, inc0_high);
   assign step1      = dtmc_step(mode_reg[`DTMC_MODE_M1_HI:`DTMC_MODE_M1_LO],
                                 t1_low_reg, t1_high_reg, inc1);

   // ********************
   // Counters and flags
   // ********************

   // A bus write to a counter byte wins over counting in that cycle.
   // Flags: a hardware set wins over a software clear in the same cycle.
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         mode_reg                 <= `DTMC_RST_BYTE;
         ctrl_reg                 <= `DTMC_RST_BYTE;
         clksel_reg               <= `DTMC_RST_BYTE;
         t0_low_reg               <= `DTMC_RST_BYTE;
         t0_high_reg              <= `DTMC_RST_BYTE;
         t1_low_reg               <= `DTMC_RST_BYTE;
         t1_high_reg              <= `DTMC_RST_BYTE;
         timer_zero_overflow_flag <= 1'b0;
         timer_one_overflow_flag  <= 1'b0;
         timer_one_overflow_tick  <= 1'b0;
      end
      else
      begin
         t0_low_reg  <= step0[7:0];
         t0_high_reg <= split ? step0_high[7:0] : step0[15:8];
         t1_low_reg  <= step1[7:0];
         t1_high_reg <= step1[15:8];
         if (wr_go && idx == `DTMC_IDX_MODE)
            mode_reg <= writedata[7:0];
         else if (wr_go && idx == `DTMC_IDX_CTRL)
            ctrl_reg <= writedata[7:0];
         else if (wr_go && idx == `DTMC_IDX_CLKSEL)
            clksel_reg <= writedata[7:0];
         else if (wr_go && idx == `DTMC_IDX_T0_LOW)
            t0_low_reg <= writedata[7:0];
         else if (wr_go && idx == `DTMC_IDX_T0_HIGH)
            t0_high_reg <= writedata[7:0];
         else if (wr_go && idx == `DTMC_IDX_T1_LOW)
            t1_low_reg <= writedata[7:0];
         else if (wr_go && idx == `DTMC_IDX_T1_HIGH)
            t1_high_reg <= writedata[7:0];
         // Flag sets are applied after any control write so they win.
         if (step0[16])
            ctrl_reg[`DTMC_CTRL_TF0] <= 1'b1;
         if (split ? step0_high[16] : step1[16])
            ctrl_reg[`DTMC_CTRL_TF1] <= 1'b1;
         timer_zero_overflow_flag <= step0[16] ||
            ((wr_go && idx == `DTMC_IDX_CTRL) ? writedata[`DTMC_CTRL_TF0]
                                              : ctrl_reg[`DTMC_CTRL_TF0]);
         timer_one_overflow_flag  <= (split ? step0_high[16] : step1[16]) ||
            ((wr_go && idx == `DTMC_IDX_CTRL) ? writedata[`DTMC_CTRL_TF1]
                                              : ctrl_reg[`DTMC_CTRL_TF1]);
         // Baud tick for the serial port, present in timer one modes 0-2, also during split; none in mode 3.
         timer_one_overflow_tick  <= step1[16];
      end
   end

   // ********************
   // Avalon-MM slave
   // ********************

   // Read mux; unmapped words read as zero.
   always @*
   begin
      rdata_next = 32'h0000_0000;
      if (!hit)
         rdata_next = 32'h0000_0000;
      else if (idx == `DTMC_IDX_MODE)
         rdata_next[7:0] = mode_reg;
      else if (idx == `DTMC_IDX_CTRL)
         rdata_next[7:0] = ctrl_reg;
      else if (idx == `DTMC_IDX_CLKSEL)
         rdata_next[7:0] = {2'h0, clksel_reg[5:0]};
      else if (idx == `DTMC_IDX_T0_LOW)
         rdata_next[7:0] = t0_low_reg;
      else if (idx == `DTMC_IDX_T0_HIGH)
         rdata_next[7:0] = t0_high_reg;
      else if (idx == `DTMC_IDX_T1_LOW)
         rdata_next[7:0] = t1_low_reg;
      else if (idx == `DTMC_IDX_T1_HIGH)
         rdata_next[7:0] = t1_high_reg;
   end

   // Every access takes one wait cycle; read data is caught at the edge
   // that drops waitrequest, so it matches the state one cycle before.
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
      end
      else if (waitrequest && (read || write))
      begin
         waitrequest <= 1'b0;
         readdata    <= read ? rdata_next : 32'h0000_0000;
      end
      else
      begin
         waitrequest <= 1'b1;
      end
   end

endmodule // dtmc_timer

// File: tb/dtmc_timer_sva.sv
// Checker for the dual timer bus handshake, mode register and overflow outputs.
`timescale 1ns/1ps
module dtmc_timer_sva
(
   input logic        clock,
   input logic        sys_rst,
   input logic [9:0]  address,
   input logic        read,
   input logic        write,
   input logic [31:0] writedata,
   input logic [3:0]  byteenable,
   input logic [31:0] readdata,
   input logic        waitrequest,
   input logic        timer_zero_overflow_flag,
   input logic        timer_one_overflow_flag,
   input logic        timer_one_overflow_tick
);
   logic [7:0] mode_reg;
   wire        done = !waitrequest && (read || write);
   wire        ok = address[1:0] == 2'h0 && address[9:2] >= 8'h88 && address[9:2] <= 8'h8e;
   // Shadow of the mode register, updated only at completed writes.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         mode_reg <= 8'h00;
      else if (done && write && byteenable[0] && address == 10'h224)
         mode_reg <= writedata[7:0];
   end
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered next cycle");
   a_wait_single: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_wait_idle: assert property (!(read || write) |=> waitrequest)
      else $error("waitrequest low without a request");
   a_upper_zero: assert property (done && read |-> readdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_mode_readback: assert property (done && read && address == 10'h224 |-> readdata[7:0] == mode_reg)
      else $error("mode register read differs from last write");
   a_unmapped_zero: assert property (done && read && !ok |-> readdata == 32'h0)
      else $error("unmapped read not zero");
   a_inactive_quiet: assert property (mode_reg[5:4] == 2'h3 && $past(mode_reg[5:4]) == 2'h3 |-> !timer_one_overflow_tick)
      else $error("tick while timer one inactive");
   a_tick_flag: assert property (timer_one_overflow_tick && mode_reg[1:0] != 2'h3 |-> ##[0:2] timer_one_overflow_flag)
      else $error("timer one overflow did not set its flag");
   a_reset_state: assert property ($fell(sys_rst) |-> waitrequest && !timer_one_overflow_tick && !timer_zero_overflow_flag && !timer_one_overflow_flag)
      else $error("outputs not at reset state");
endmodule // dtmc_timer_sva

bind dtmc_timer dtmc_timer_sva i_sva (.clock, .sys_rst, .address, .read, .write, .writedata,
   .byteenable, .readdata, .waitrequest, .timer_zero_overflow_flag, .timer_one_overflow_flag,
   .timer_one_overflow_tick);

// File: tb/dtmc_pin_model.sv
// Pin-side partner: count pulses, gate levels and a free external clock.
`timescale 1ns/1ps
module dtmc_pin_model
(
   input  logic        clock,
   input  logic [1:0]  pulse_on,
   input  logic [1:0]  gate_lvl,
   output logic [1:0]  count_pins,
   output logic [1:0]  irq_pins,
   output logic        external_clock,
   output logic [15:0] falls
);
   logic [2:0] ph;
   // The oscillator is unrelated in phase to the system clock.
   initial
   begin
      external_clock = 1'b0;
      ph = 3'h0;
      count_pins = 2'h3;
      falls = 16'h0;
      forever #13 external_clock = ~external_clock;
   end
   assign irq_pins = gate_lvl;
   // Eight clocks per level keep each edge clear of the synchronisers; a pin is never left low.
   always @(posedge clock)
   begin
      ph <= ph + 3'h1;
      if (ph == 3'h0)
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (pulse_on[i] || !count_pins[i])
               count_pins[i] <= !count_pins[i];
            if (pulse_on[i] && count_pins[i])
               falls[i*8 +: 8] <= falls[i*8 +: 8] + 8'h1;
         end
      end
   end
endmodule // dtmc_pin_model

// File: tb/dual_timer_mode_control_bench.sv
// Self-checking bench of the dual timer block.
`timescale 1ns/1ps
module dual_timer_mode_control_bench;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic [9:0]  address = 10'h0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   wire  [2:0]  evs;
   logic [1:0]  cpins;
   logic [1:0]  ipins;
   logic [1:0]  pulse_on = 2'h0;
   logic [1:0]  gate_lvl = 2'h3;
   logic        xclk;
   logic [15:0] falls;
   logic [15:0] base;
   logic [7:0]  rd;
   logic        seen;
   int          n;
   int          n_errors = 0;
   int          samples_checked = 0;
   logic [23:0] rows [5] = '{24'h89a5a5, 24'h895a5a, 24'h8a3c3c, 24'h90ff00, 24'h8eff3f};
   int          divs [3] = '{12, 4, 48};

   // 200 MHz system clock.
   initial
   begin
      forever #2.5 clock = ~clock;
   end

   dtmc_timer i_dut (.clock, .sys_rst, .address, .read, .write, .writedata, .byteenable(4'h1),
      .readdata, .waitrequest, .timer_zero_count_pin(cpins[0]), .timer_one_count_pin(cpins[1]),
      .ext_irq_zero_pin(ipins[0]), .ext_irq_one_pin(ipins[1]), .external_clock(xclk),
      .timer_zero_overflow_flag(evs[0]), .timer_one_overflow_flag(evs[1]),
      .timer_one_overflow_tick(evs[2]));
   dtmc_pin_model i_pins (.clock, .pulse_on, .gate_lvl, .count_pins(cpins), .irq_pins(ipins),
      .external_clock(xclk), .falls);

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask

   // One bus transfer; the request stands until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int k;
      @(posedge clock);
      address <= {idx, 2'h0};
      writedata <= {24'h0, d};
      read <= !wr;
      write <= wr;
      k = 0;
      do
      begin
         @(posedge clock);
         k++;
      end
      while (waitrequest !== 1'b0 && k < 50);
      if (waitrequest !== 1'b0)
      begin
         n_errors++;
         close_out();
      end
      rd = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      check(rd, exp);
   endtask

   // Waits for one of tick, flag one, flag zero; the cycle count is returned.
   task automatic wait_ev(input int w, output int cnt);
      cnt = 0;
      do
      begin
         @(posedge clock);
         cnt++;
      end
      while (evs[w] !== 1'b1 && cnt < 400);
      if (evs[w] !== 1'b1)
      begin
         n_errors++;
         close_out();
      end
   endtask

   task automatic quiet(input int w);
      seen = 1'b0;
      repeat (40)
      begin
         @(posedge clock);
         seen = seen | evs[w];
      end
   endtask

   // ********************
   // Main sequence
   // ********************
   initial
   begin
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      rdchk(8'h89, 8'h00);
      foreach (rows[i])
      begin
         wr(rows[i][23:16], rows[i][15:8]);
         rdchk(rows[i][23:16], rows[i][7:0]);
      end
      $display("registers done");
      // Both wide modes must wrap the high byte to zero and raise the flag.
      for (int m = 0; m < 2; m++)
      begin
         wr(8'h88, 8'h00);
         wr(8'h8e, 8'h04);
         wr(8'h89, m[7:0]);
         wr(8'h8c, 8'hff);
         wr(8'h8a, 8'hfc);
         wr(8'h88, 8'h10);
         wait_ev(0, n);
         wr(8'h88, 8'h00);
         rdchk(8'h8c, 8'h00);
      end
      // Timer zero reload: low byte runs fd, fe, ff, then overflows and reloads.
      wr(8'h89, 8'h02);
      wr(8'h8c, 8'hfd);
      wr(8'h8a, 8'hfd);
      wr(8'h88, 8'h10);
      wait_ev(0, n);
      check(n, 4);
      wr(8'h88, 8'h00);
      $display("wrap done");
      wr(8'h8e, 8'h08);
      wr(8'h89, 8'h20);
      wr(8'h8d, 8'hfb);
      wr(8'h88, 8'h40);
      wait_ev(2, n);
      wait_ev(2, n);
      check(n, 5);
      rdchk(8'h88, 8'hc0);
      wr(8'h8d, 8'hff);
      foreach (divs[s])
      begin
         wr(8'h8e, s[7:0]);
         // The first tick may still come from the old rate, so time the third.
         wait_ev(2, n);
         wait_ev(2, n);
         wait_ev(2, n);
         check(n, divs[s]);
      end
      wr(8'h8e, 8'h03);
      wait_ev(2, n);
      wait_ev(2, n);
      wait_ev(2, n);
      check(n >= 40 && n <= 43, 1);
      $display("prescale done");
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h99);
      wr(8'h8e, 8'h0c);
      wr(8'h8c, 8'hff);
      wr(8'h8d, 8'hff);
      wr(8'h8a, 8'hf0);
      wr(8'h8b, 8'hf0);
      wr(8'h88, 8'h50);
      quiet(0);
      check(seen, 0);
      quiet(1);
      check(seen, 0);
      gate_lvl <= 2'h0;
      wait_ev(0, n);
      wait_ev(1, n);
      $display("gate done");
      wr(8'h89, 8'h55);
      wr(8'h8a, 8'h00);
      wr(8'h8b, 8'h00);
      base = falls;
      wr(8'h88, 8'h50);
      pulse_on <= 2'h3;
      repeat (200) @(posedge clock);
      pulse_on <= 2'h0;
      repeat (30) @(posedge clock);
      wr(8'h88, 8'h00);
      rdchk(8'h8a, falls[7:0] - base[7:0]);
      rdchk(8'h8b, falls[15:8] - base[15:8]);
      $display("counter done");
      wr(8'h8e, 8'h0c);
      wr(8'h8d, 8'hfb);
      wr(8'h8c, 8'hf0);
      wr(8'h89, 8'h23);
      wait_ev(2, n);
      wait_ev(2, n);
      check(n, 5);
      check(evs[1], 0);
      wr(8'h89, 8'h33);
      quiet(2);
      check(seen, 0);
      rdchk(8'h8c, 8'hf0);
      wr(8'h88, 8'h40);
      wait_ev(1, n);
      check(n < 30, 1);
      $display("split done");
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      rdchk(8'h89, 8'h00);
      check(evs, 3'h0);
      $display("reset done");
      close_out();
   end
endmodule // dual_timer_mode_control_bench
